// file: core/dispatch_pkg.sv
// Constants, codes and types for the digital input function dispatcher
// Overview of operation
// - Code 0x23 low raises limit alarm, reverse-only motion; high clears it
// - Code 0x24 is home switch, both edges, indexed or index I/O mode only
// - Code 0x27 rising edge starts homing, indexed mode only
// - Code 0x2B in dual mode: low selects pulse train, high indexed
// - Multi-mode combines 0x2B with the indexed/speed selector to pick mode
// - Code 0x35 rising edge runs cam alignment when cam enable bit 0 set
// - Code 0x36 high starts configured cam; cam then runs to completion
// - Codes 0x37/0x38 jog forward/reverse while high, not in I/O mode
// - Codes 0x39..0x3C fire event one..four on selectable edge
// - Code 0x43 level is gear numerator bit 0, companion bit 1, indexed or pulse mode only
// - Code 0x45 on input eight inhibits external pulses in pulse mode
// - Code 0x46 stops indexed commands with protection decel only
// - Code 0x47 rising: decel, brake, then disable and quick-stop alarm in the same cycle
// - Code 0x48 high enables drive outside I/O mode; low decelerates, brakes and disables
package dispatch_pkg;
  localparam logic [7:0] FN_FWD_LIMIT = 8'h23;
  localparam logic [7:0] FN_HOME_SW = 8'h24;
  localparam logic [7:0] FN_HOME_START = 8'h27;
  localparam logic [7:0] FN_PTPR_SEL = 8'h2B;
  localparam logic [7:0] FN_POS_SPD_SEL = 8'h18;
  localparam logic [7:0] FN_CAM_ALIGN = 8'h35;
  localparam logic [7:0] FN_CAM_ENGAGE = 8'h36;
  localparam logic [7:0] FN_JOG_FWD = 8'h37;
  localparam logic [7:0] FN_JOG_REV = 8'h38;
  localparam logic [7:0] FN_EVENT1 = 8'h39;
  localparam logic [7:0] FN_EVENT2 = 8'h3A;
  localparam logic [7:0] FN_EVENT3 = 8'h3B;
  localparam logic [7:0] FN_EVENT4 = 8'h3C;
  localparam logic [7:0] FN_GEAR_B0 = 8'h43;
  localparam logic [7:0] FN_GEAR_B1 = 8'h44;
  localparam logic [7:0] FN_PULSE_INH = 8'h45;
  localparam logic [7:0] FN_STOP = 8'h46;
  localparam logic [7:0] FN_QUICK_STOP = 8'h47;
  localparam logic [7:0] FN_SERVO_ON = 8'h48;
  localparam int N_FUNC = 19;
  localparam logic [7:0] FUNC_CODES [N_FUNC] = '{
    FN_FWD_LIMIT, FN_HOME_SW, FN_HOME_START, FN_PTPR_SEL, FN_POS_SPD_SEL,
    FN_CAM_ALIGN, FN_CAM_ENGAGE, FN_JOG_FWD, FN_JOG_REV, FN_EVENT1,
    FN_EVENT2, FN_EVENT3, FN_EVENT4, FN_GEAR_B0, FN_GEAR_B1, FN_PULSE_INH,
    FN_STOP, FN_QUICK_STOP, FN_SERVO_ON};
  localparam int F_FWD = 0;
  localparam int F_HOME = 1;
  localparam int F_HSTART = 2;
  localparam int F_PTPR = 3;
  localparam int F_POSSPD = 4;
  localparam int F_CALIGN = 5;
  localparam int F_CENG = 6;
  localparam int F_JOGF = 7;
  localparam int F_JOGR = 8;
  localparam int F_EVT1 = 9;
  localparam int F_GB0 = 13;
  localparam int F_GB1 = 14;
  localparam int F_PINH = 15;
  localparam int F_STOP = 16;
  localparam int F_QSTOP = 17;
  localparam int F_SERVO = 18;
  localparam int N_EVENT = 4;
  localparam int PULSE_INH_INPUT = 7;
  localparam int CAM_EN_BIT = 0;
  localparam int BRAKE_CNT_W = 16;
  localparam logic [BRAKE_CNT_W-1:0] RST_BRAKE_CNT = 16'h0000;
  localparam logic [2:0] RST_MODE = 3'h0;
  typedef enum logic [2:0] {
    MODE_PULSE, MODE_INDEX, MODE_S, MODE_T, MODE_IO, MODE_DUAL_PTPR, MODE_MULTI
  } op_mode_t;
  typedef enum logic [1:0] {SV_OFF, SV_ON, SV_DECEL, SV_BRAKE} servo_state_t;
endpackage : dispatch_pkg

// file: core/input_sync.sv
// Three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
module input_sync #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, rise_q, fall_q;
  wire [W-1:0] agree = ~(s2_q ^ s3_q);
  wire [W-1:0] lvl_d = (agree & s3_q) | (~agree & lvl_q);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
      rise_q <= '0;
      fall_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      rise_q <= lvl_d & ~lvl_q;
      fall_q <= ~lvl_d & lvl_q;
    end
  end
  assign lvl = lvl_q;
  assign rise = rise_q;
  assign fall = fall_q;
  a_sync_edge: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(lvl_q[0]) |-> rise_q[0] && !fall_q[0])
    else $error("edge pulse missing on level rise");
endmodule : input_sync

// file: core/input_function_dispatch.sv
// Maps configurable digital inputs to drive functions and acts on them
`timescale 1ns/1ns
module input_function_dispatch
  import dispatch_pkg::*;
#(
  parameter int N_IN = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [N_IN-1:0] di_pin,
  input wire logic [N_IN*8-1:0] di_func,
  input wire logic [2:0] op_mode,
  input wire logic [7:0] cam_ctrl,
  input wire logic cam_di_mode,
  input wire logic cam_busy,
  input wire logic [N_EVENT-1:0] event_on_fall,
  input wire logic brake_fitted,
  input wire logic [BRAKE_CNT_W-1:0] brake_delay,
  input wire logic motor_stopped,
  input wire logic alarm_clear,
  output logic fwd_limit_alarm,
  output logic reverse_only,
  output logic home_switch_edge,
  output logic homing_start,
  output logic [2:0] active_mode,
  output logic cam_align_start,
  output logic cam_engage,
  output logic jog_fwd,
  output logic jog_rev,
  output logic [N_EVENT-1:0] event_fire,
  output logic [1:0] gear_num_sel,
  output logic pulse_inhibit,
  output logic idx_stop,
  output logic drive_enable,
  output logic prot_decel,
  output logic brake_engage,
  output logic quick_stop_alarm
);
  if (N_IN < PULSE_INH_INPUT + 1) begin : g_chk
    $error("N_IN must cover digital input eight");
  end

  logic [N_IN-1:0] s_lvl, s_rise, s_fall;
  input_sync #(.W(N_IN)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin(di_pin),
    .lvl(s_lvl),
    .rise(s_rise),
    .fall(s_fall)
  );

  // Per function: which inputs carry it, and its level and edges
  logic [N_FUNC-1:0] f_asg, f_lvl, f_rise, f_fall;
  for (genvar f = 0; f < N_FUNC; f++) begin : g_func
    logic [N_IN-1:0] hit;
    for (genvar i = 0; i < N_IN; i++) begin : g_in
      assign hit[i] = di_func[i*8 +: 8] == FUNC_CODES[f];
    end
    assign f_asg[f] = |hit;
    assign f_lvl[f] = |(hit & s_lvl);
    assign f_rise[f] = |(hit & s_rise);
    assign f_fall[f] = |(hit & s_fall);
  end

  // Mode resolution
  op_mode_t cfg_mode, eff_mode, dual_mode;
  assign cfg_mode = op_mode_t'(op_mode);
  assign dual_mode = f_lvl[F_PTPR] ? MODE_INDEX : MODE_PULSE;
  always_comb begin
    case (cfg_mode)
      MODE_DUAL_PTPR: eff_mode = dual_mode;
      MODE_MULTI: begin
        if (f_lvl[F_POSSPD]) eff_mode = MODE_S;
        else eff_mode = dual_mode;
      end
      default: eff_mode = cfg_mode;
    endcase
  end
  wire m_idx = eff_mode == MODE_INDEX;
  wire m_pul = eff_mode == MODE_PULSE;
  wire m_io = eff_mode == MODE_IO;
  wire m_qs = m_pul | m_idx | eff_mode == MODE_S | eff_mode == MODE_T;

  // Level and edge function decode
  wire fwd_alarm_d = f_asg[F_FWD] & ~f_lvl[F_FWD];
  wire home_d = (m_idx | m_io) & (f_rise[F_HOME] | f_fall[F_HOME]);
  wire hstart_d = m_idx & f_rise[F_HSTART];
  wire calign_d = f_rise[F_CALIGN] & cam_ctrl[CAM_EN_BIT];
  wire ceng_d = cam_di_mode & f_lvl[F_CENG] & ~cam_busy;
  wire jogf_d = ~m_io & f_lvl[F_JOGF];
  wire jogr_d = ~m_io & f_lvl[F_JOGR];
  wire gear_ok = m_idx | m_pul;
  wire [1:0] gear_d = gear_ok ? {f_lvl[F_GB1], f_lvl[F_GB0]} : 2'h0;
  wire pinh_d = m_pul & s_lvl[PULSE_INH_INPUT] &
    (di_func[PULSE_INH_INPUT*8 +: 8] == FN_PULSE_INH);
  wire stop_d = m_idx & f_lvl[F_STOP];
  wire [N_EVENT-1:0] ev_d;
  for (genvar e = 0; e < N_EVENT; e++) begin : g_ev
    assign ev_d[e] = event_on_fall[e] ? f_fall[F_EVT1+e]
                                      : f_rise[F_EVT1+e];
  end

  // Servo-on, quick stop and brake sequence
  servo_state_t sv_q, sv_d;
  logic qs_pend_q, qs_alarm_q;
  logic [BRAKE_CNT_W-1:0] bcnt_q, bcnt_d;
  wire servo_req = f_lvl[F_SERVO] & ~m_io & ~qs_alarm_q;
  wire qs_trig = m_qs & f_rise[F_QSTOP];
  wire seq_done = (sv_q == SV_DECEL & motor_stopped & ~brake_fitted) |
                  (sv_q == SV_BRAKE & bcnt_q == RST_BRAKE_CNT);
  always_comb begin
    sv_d = sv_q;
    bcnt_d = bcnt_q;
    case (sv_q)
      SV_OFF: if (servo_req) sv_d = SV_ON;
      SV_ON: if (!servo_req || qs_trig) sv_d = SV_DECEL;
      SV_DECEL: begin
        if (motor_stopped) begin
          sv_d = brake_fitted ? SV_BRAKE : SV_OFF;
          bcnt_d = brake_delay;
        end
      end
      SV_BRAKE: begin
        if (bcnt_q == RST_BRAKE_CNT) sv_d = SV_OFF;
        else bcnt_d = bcnt_q - 1'b1;
      end
      default: sv_d = SV_OFF;
    endcase
  end
  wire qs_pend_d = (sv_q == SV_ON & qs_trig) | (qs_pend_q & ~seq_done);
  // Completion sets the alarm even if cleared in the same cycle
  wire qs_alarm_d = (qs_pend_q & seq_done) | (qs_alarm_q & ~alarm_clear);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sv_q <= SV_OFF;
      bcnt_q <= RST_BRAKE_CNT;
      qs_pend_q <= 1'b0;
      qs_alarm_q <= 1'b0;
    end else begin
      sv_q <= sv_d;
      bcnt_q <= bcnt_d;
      qs_pend_q <= qs_pend_d;
      qs_alarm_q <= qs_alarm_d;
    end
  end

  logic fwd_q, home_q, hstart_q, calign_q, ceng_q, jogf_q, jogr_q;
  logic pinh_q, stop_q, en_q, decel_q, brake_q;
  logic [N_EVENT-1:0] ev_q;
  logic [1:0] gear_q;
  logic [2:0] mode_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {fwd_q, home_q, hstart_q, calign_q, ceng_q, jogf_q, jogr_q} <= '0;
      {pinh_q, stop_q, en_q, decel_q} <= '0;
      brake_q <= 1'b1;
      ev_q <= '0;
      gear_q <= 2'h0;
      mode_q <= RST_MODE;
    end else begin
      fwd_q <= fwd_alarm_d;
      home_q <= home_d;
      hstart_q <= hstart_d;
      calign_q <= calign_d;
      ceng_q <= ceng_d;
      jogf_q <= jogf_d;
      jogr_q <= jogr_d;
      pinh_q <= pinh_d;
      stop_q <= stop_d;
      ev_q <= ev_d;
      gear_q <= gear_d;
      mode_q <= eff_mode;
      en_q <= sv_d != SV_OFF;
      decel_q <= sv_d == SV_DECEL | stop_d;
      brake_q <= sv_d == SV_OFF | sv_d == SV_BRAKE;
    end
  end

  assign fwd_limit_alarm = fwd_q;
  assign reverse_only = fwd_q;
  assign home_switch_edge = home_q;
  assign homing_start = hstart_q;
  assign active_mode = mode_q;
  assign cam_align_start = calign_q;
  assign cam_engage = ceng_q;
  assign jog_fwd = jogf_q;
  assign jog_rev = jogr_q;
  assign event_fire = ev_q;
  assign gear_num_sel = gear_q;
  assign pulse_inhibit = pinh_q;
  assign idx_stop = stop_q;
  assign drive_enable = en_q;
  assign prot_decel = decel_q;
  assign brake_engage = brake_q;
  assign quick_stop_alarm = qs_alarm_q;

  a_fwd_alarm: assert property (@(posedge clk_sys) disable iff (!nrst)
    f_asg[F_FWD] && !f_lvl[F_FWD] |=> fwd_limit_alarm && reverse_only)
    else $error("forward limit alarm not raised");
  a_home_mode: assert property (@(posedge clk_sys) disable iff (!nrst)
    home_switch_edge |-> $past(m_idx || m_io))
    else $error("home switch edge outside allowed modes");
  a_homing_pulse: assert property (@(posedge clk_sys) disable iff (!nrst)
    homing_start |=> !homing_start)
    else $error("homing start longer than one cycle");
  a_dual_select: assert property (@(posedge clk_sys) disable iff (!nrst)
    cfg_mode == MODE_DUAL_PTPR |=> active_mode == $past(dual_mode))
    else $error("dual mode selection wrong");
  a_multi_speed: assert property (@(posedge clk_sys) disable iff (!nrst)
    cfg_mode == MODE_MULTI && f_lvl[F_POSSPD] |=> active_mode == MODE_S)
    else $error("multi mode did not select speed");
  a_cam_align: assert property (@(posedge clk_sys) disable iff (!nrst)
    cam_align_start |-> $past(cam_ctrl[CAM_EN_BIT]))
    else $error("cam alignment without cam enable");
  a_jog_io: assert property (@(posedge clk_sys) disable iff (!nrst)
    (jog_fwd || jog_rev) |-> $past(!m_io))
    else $error("jog active in I/O mode");
  a_event_edge: assert property (@(posedge clk_sys) disable iff (!nrst)
    f_rise[F_EVT1] && !event_on_fall[0] |=> event_fire[0])
    else $error("event one not fired on rising edge");
  a_gear_mode: assert property (@(posedge clk_sys) disable iff (!nrst)
    gear_num_sel != 2'h0 |-> $past(gear_ok))
    else $error("gear selection outside indexed or pulse mode");
  a_pulse_inh: assert property (@(posedge clk_sys) disable iff (!nrst)
    pulse_inhibit |-> $past(m_pul && s_lvl[PULSE_INH_INPUT]))
    else $error("pulse inhibit without input eight in pulse mode");
  a_qs_alarm: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(quick_stop_alarm) |-> !drive_enable ##1 !drive_enable)
    else $error("quick stop alarm while drive enabled");
  a_servo_off: assert property (@(posedge clk_sys) disable iff (!nrst)
    sv_q == SV_ON && !servo_req |=> prot_decel && drive_enable)
    else $error("servo off did not start deceleration");
endmodule : input_function_dispatch

// file: dv/field_side.sv
// Field contacts and a motion core stand-in facing the input dispatcher
`timescale 1ns/1ns
module field_side (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [8:0] contact_closed,
  input wire logic prot_decel,
  output logic [8:0] di_pin,
  output logic motor_stopped
);
  logic [2:0] ramp_q;
  logic [2:0] ramp_d;
  // Normally-open contacts: an open circuit reads as off
  assign di_pin = contact_closed;
  // Motor needs four cycles of deceleration before it reports standstill
  assign motor_stopped = (ramp_q == 3'h4);
  assign ramp_d = !prot_decel ? 3'h0 : (motor_stopped ? ramp_q : ramp_q + 3'h1);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ramp_q <= 3'h0;
    end else begin
      ramp_q <= ramp_d;
    end
  end
endmodule : field_side

// file: dv/input_function_dispatch_tb.sv
// Self-checking bench for the digital input function dispatcher
`timescale 1ns/1ns
module input_function_dispatch_tb
  import dispatch_pkg::*;
;
  logic clk_sys = 1'b0, nrst = 1'b0, cam_di_mode = 1'b0, alarm_clear = 1'b0;
  logic brake_fitted = 1'b1, motor_stopped;
  logic [8:0] sw = '0, di_pin;
  logic [2:0] op_mode = 3'h1, active_mode;
  logic [3:0] event_on_fall = 4'h0, event_fire;
  logic [15:0] brake_delay = 16'h0003;
  logic [71:0] di_func = {FN_HOME_SW, FN_PULSE_INH, FN_QUICK_STOP,
    FN_SERVO_ON, FN_GEAR_B0, FN_EVENT1, FN_JOG_FWD, FN_HOME_START,
    FN_FWD_LIMIT};
  logic [7:0] cam_ctrl = 8'h01;
  logic cam_busy = 1'b0;
  logic [1:0] gear_num_sel;
  logic fwd_limit_alarm, reverse_only, home_switch_edge, homing_start;
  logic cam_align_start, cam_engage, jog_fwd, jog_rev, pulse_inhibit, idx_stop;
  logic drive_enable, prot_decel, brake_engage, quick_stop_alarm;
  int n_mismatch = 0, checks_done = 0, n_home, n_hsw, n_ev, n_evx, n_dec;
  int n_cal;
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  field_side u_field (.clk_sys(clk_sys), .nrst(nrst), .contact_closed(sw),
    .prot_decel(prot_decel), .di_pin(di_pin), .motor_stopped(motor_stopped));
  input_function_dispatch #(.N_IN(9)) u_dut (.clk_sys(clk_sys), .nrst(nrst),
    .di_pin(di_pin), .di_func(di_func), .op_mode(op_mode),
    .cam_ctrl(cam_ctrl), .cam_di_mode(cam_di_mode), .cam_busy(cam_busy),
    .event_on_fall(event_on_fall),
    .brake_fitted(brake_fitted), .brake_delay(brake_delay),
    .motor_stopped(motor_stopped), .alarm_clear(alarm_clear),
    .fwd_limit_alarm(fwd_limit_alarm), .reverse_only(reverse_only),
    .home_switch_edge(home_switch_edge), .homing_start(homing_start),
    .active_mode(active_mode), .cam_align_start(cam_align_start),
    .cam_engage(cam_engage), .jog_fwd(jog_fwd), .jog_rev(jog_rev),
    .event_fire(event_fire), .gear_num_sel(gear_num_sel),
    .pulse_inhibit(pulse_inhibit), .idx_stop(idx_stop),
    .drive_enable(drive_enable), .prot_decel(prot_decel),
    .brake_engage(brake_engage), .quick_stop_alarm(quick_stop_alarm));
  // Count cycles in which pulse outputs and prot_decel are high
  always @(posedge clk_sys) begin
    n_home += (homing_start === 1'b1);
    n_hsw += (home_switch_edge === 1'b1);
    n_ev += (event_fire[0] === 1'b1);
    n_evx += (event_fire[3:1] !== 3'h0);
    n_dec += (prot_decel === 1'b1);
    n_cal += (cam_align_start === 1'b1);
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [3:0] exp,
                     input logic [3:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic pin(input int i, input logic v, input int n);
    sw[i] = v;
    tick(n);
  endtask : pin
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic t_limit();
    chk("fwd_limit_alarm", 4'h1, {3'h0, fwd_limit_alarm});
    pin(0, 1'b1, 7);
    chk("fwd_limit_alarm", 4'h0, {3'h0, fwd_limit_alarm});
    chk("reverse_only", 4'h0, {3'h0, reverse_only});
    pin(0, 1'b0, 7);
    chk("reverse_only", 4'h1, {3'h0, reverse_only});
  endtask : t_limit
  task automatic t_homing();
    n_home = 0;
    pin(1, 1'b1, 8);
    chk("homing_start", 4'h1, n_home[3:0]);
    pin(1, 1'b0, 7);
    op_mode = 3'h4;
    pin(1, 1'b1, 8);
    chk("homing_start", 4'h1, n_home[3:0]);
    n_hsw = 0;
    pin(8, 1'b1, 8);
    pin(8, 1'b0, 8);
    chk("home_switch_edge", 4'h2, n_hsw[3:0]);
    op_mode = 3'h2;
    pin(8, 1'b1, 8);
    chk("home_switch_edge", 4'h2, n_hsw[3:0]);
  endtask : t_homing
  task automatic t_jog_gear();
    op_mode = 3'h0;
    pin(2, 1'b1, 7);
    pin(4, 1'b1, 7);
    pin(7, 1'b1, 7);
    chk("jog_fwd", 4'h1, {2'h0, jog_rev, jog_fwd});
    chk("gear_num_sel", 4'h1, {2'h0, gear_num_sel});
    chk("pulse_inhibit", 4'h1, {3'h0, pulse_inhibit});
    op_mode = 3'h4;
    tick(3);
    chk("jog_fwd", 4'h0, {2'h0, jog_rev, jog_fwd});
    chk("gear_num_sel", 4'h0, {2'h0, gear_num_sel});
    chk("pulse_inhibit", 4'h0, {3'h0, pulse_inhibit});
  endtask : t_jog_gear
  task automatic t_event();
    op_mode = 3'h1;
    for (int p = 0; p < 2; p++) begin
      event_on_fall = {3'h0, p[0]};
      n_ev = 0;
      pin(3, 1'b1, 8);
      chk("event_fire rise", {3'h0, ~p[0]}, n_ev[3:0]);
      pin(3, 1'b0, 8);
      chk("event_fire total", 4'h1, n_ev[3:0]);
    end
    chk("event_fire others", 4'h0, n_evx[3:0]);
  endtask : t_event
  task automatic t_servo();
    pin(5, 1'b1, 9);
    chk("drive_enable", 4'h1, {2'h0, brake_engage, drive_enable});
    n_dec = 0;
    pin(6, 1'b1, 30);
    chk("decel seen", 4'h1, {3'h0, n_dec != 0});
    chk("qs drive off", 4'h2, {2'h0, brake_engage, drive_enable});
    chk("quick_stop_alarm", 4'h1, {3'h0, quick_stop_alarm});
    alarm_clear = 1'b1;
    tick(1);
    alarm_clear = 1'b0;
    tick(6);
    chk("quick_stop_alarm", 4'h0, {3'h0, quick_stop_alarm});
    chk("drive_enable", 4'h1, {2'h0, brake_engage, drive_enable});
    n_dec = 0;
    pin(5, 1'b0, 30);
    chk("decel seen", 4'h1, {3'h0, n_dec != 0});
    chk("servo off", 4'h2, {2'h0, brake_engage, drive_enable});
    chk("quick_stop_alarm", 4'h0, {3'h0, quick_stop_alarm});
  endtask : t_servo
  task automatic t_misc();
    op_mode = 3'h5;
    di_func[2*8 +: 8] = FN_PTPR_SEL;
    tick(2);
    chk("active_mode", 4'h1, {1'b0, active_mode});
    pin(2, 1'b0, 7);
    chk("active_mode", 4'h0, {1'b0, active_mode});
    op_mode = 3'h6;
    di_func[4*8 +: 8] = FN_POS_SPD_SEL;
    tick(2);
    chk("active_mode", 4'h2, {1'b0, active_mode});
    op_mode = 3'h1;
    di_func[2*8 +: 8] = FN_STOP;
    di_func[4*8 +: 8] = FN_CAM_ENGAGE;
    cam_di_mode = 1'b1;
    pin(2, 1'b1, 7);
    chk("idx_stop", 4'h3, {2'h0, prot_decel, idx_stop});
    chk("cam_engage", 4'h1, {3'h0, cam_engage});
    cam_busy = 1'b1;
    tick(2);
    chk("cam_engage", 4'h0, {3'h0, cam_engage});
    di_func[3*8 +: 8] = FN_CAM_ALIGN;
    n_cal = 0;
    pin(3, 1'b1, 8);
    pin(3, 1'b0, 8);
    cam_ctrl = 8'h00;
    pin(3, 1'b1, 8);
    chk("cam_align_start", 4'h1, n_cal[3:0]);
  endtask : t_misc
  initial begin
    tick(3);
    chk("reset outputs", 4'h2, {2'h0, brake_engage, drive_enable});
    nrst = 1'b1;
    tick(8);
    t_limit();
    t_homing();
    t_jog_gear();
    t_event();
    t_servo();
    t_misc();
    wrap_up();
  end
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
endmodule : input_function_dispatch_tb
